// [core/dtb_pkg.sv]
// Shared constants and types of the data transfer bus slave and its time-out monitor
package dtb_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int ADDR_W      = 23;     // Address lines A01 upward, bit 0 is A01
    localparam int DATA_W      = 16;
    localparam int AM_W        = 6;
    localparam int MEM_AW      = 10;     // Word index bits of the local store
    localparam int LANE_ODD    = 0;      // D00-D07, strobed by the odd byte strobe
    localparam int LANE_EVEN   = 1;      // D08-D15, strobed by the even byte strobe

    ////////////////////////////////////////////////////////////////////////////////
    // Decode defaults (arbitrary values)
    localparam logic [ADDR_W-1:0] DEF_BASE_ADDR = 23'h000000;
    localparam logic [AM_W-1:0]   DEF_AM_CODE   = 6'h3D;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_NS          = 10;
    localparam int RELEASE_NS      = 30;
    localparam int RELEASE_CYC     = (RELEASE_NS / CLK_NS < 1) ? 1 : RELEASE_NS / CLK_NS;
    localparam int DEF_TIMEOUT_CYC = 100;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic       LINE_IDLE  = 1'b1;   // Bus lines sampled high after reset
    localparam logic [1:0] LANES_OFF  = 2'h0;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_SEL    = 7'h02,
        ST_STRB   = 7'h04,
        ST_RDWAIT = 7'h08,
        ST_DRIVE  = 7'h10,
        ST_ACK    = 7'h20,
        ST_ERR    = 7'h40
    } slv_state_t;

endpackage

// [core/dtb_word_mem.sv]
// Word store of the slave with byte-lane writes and registered read data
`timescale 1ns/1ns
module dtb_word_mem #(
    parameter int AW = dtb_pkg::MEM_AW,
    parameter int DW = dtb_pkg::DATA_W
) (
    input  wire logic          i_mclk,
    input  wire logic          i_reset_n,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic          i_wr,
    input  wire logic [1:0]    i_be,
    input  wire logic [DW-1:0] i_wdata,
    input  wire logic          i_rd,
    output logic      [DW-1:0] o_rdata
);
    localparam int DEPTH = 1 << AW;
    localparam int LW    = DW / 2;

    if (DW % 2 != 0 || AW < 1) begin : g_chk
        $error("dtb_word_mem needs an even data width and at least one address bit");
    end

    typedef struct packed {
        logic [DEPTH-1:0][DW-1:0] mem;
        logic [DW-1:0]            rdata;
    } mem_state_t;

    mem_state_t s_q;
    mem_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (i_rd) begin
            s_d.rdata = s_q.mem[i_addr];
        end
        for (int lane = 0; lane < 2; lane++) begin
            if (i_wr && i_be[lane]) begin
                s_d.mem[i_addr][lane*LW +: LW] = i_wdata[lane*LW +: LW];
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata = s_q.rdata;

endmodule

// [core/dtb_slave.sv]
// Word-wide slave of the data transfer bus with the bus time-out monitor
`timescale 1ns/1ns

// Contract
// R1 - Strobe fall starts delay; expiry drives error
// R2 - Monitor never errors before strobe falls
// R3 - Acknowledge, error or strobe rise cancels delay
// R4 - Monitor releases error after strobe rises
// R5 - Master transfers only after gaining ownership
// R6 - Address, modifier, widths valid before address strobe
// R7 - Slave selects only on address match
// R8 - Master sets direction before data strobes
// R9 - Master waits for acknowledge lines high
// R10 - Odd byte uses odd strobe only
// R11 - Read data valid before acknowledge, held
// R12 - Master captures byte before terminating
// R13 - Master releases address, then raises strobes
// R14 - Strobes high: release data and acknowledge
// R15 - Word write latched, stored, then acknowledged
// R16 - Master may chain cycles keeping ownership
// R17 - No response before a data strobe falls
// R18 - Lanes follow width, A01 and strobes
// R19 - Departing master releases strobe last
// R20 - Time-out length is a clock-cycle parameter
module dtb_slave #(
    parameter int                          MEM_AW      = dtb_pkg::MEM_AW,
    parameter logic [dtb_pkg::ADDR_W-1:0]  BASE_ADDR   = dtb_pkg::DEF_BASE_ADDR,
    parameter logic [dtb_pkg::AM_W-1:0]    AM_CODE     = dtb_pkg::DEF_AM_CODE,
    parameter int                          TIMEOUT_CYC = dtb_pkg::DEF_TIMEOUT_CYC
) (
    input  wire logic                        i_mclk,
    input  wire logic                        i_reset_n,
    input  wire logic [dtb_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [dtb_pkg::AM_W-1:0]    i_am,
    input  wire logic                        i_iack_n,
    input  wire logic                        i_lword_n,
    input  wire logic                        i_write_n,
    input  wire logic                        i_as_n,
    input  wire logic                        i_ds0_n,
    input  wire logic                        i_ds1_n,
    input  wire logic [dtb_pkg::DATA_W-1:0]  i_data,
    output logic      [dtb_pkg::DATA_W-1:0]  o_data,
    output logic      [1:0]                  o_data_oe,
    input  wire logic                        i_dtack_n,
    output logic                             o_dtack_oe,
    input  wire logic                        i_berr_n,
    output logic                             o_berr_oe
);
    localparam int DW = dtb_pkg::DATA_W;
    localparam int AW = dtb_pkg::ADDR_W;

    if (TIMEOUT_CYC < 2 || MEM_AW < 1 || MEM_AW >= AW) begin : g_chk
        $error("dtb_slave: TIMEOUT_CYC must be 2 or more, MEM_AW within the address"); // R20
    end

    typedef struct packed {
        dtb_pkg::slv_state_t st;
        logic [MEM_AW-1:0]   idx;
        logic                as_n;
        logic [1:0]          ds_n;
        logic                dtack_n;
        logic                berr_n;
        logic [DW-1:0]       data;
        logic [1:0]          oe;
        logic                dtack;
        logic                sberr;
        logic                tmo_run;
        logic [31:0]         tmo_cnt;
        logic                tmo_berr;
    } slv_t;

    slv_t          s_q;
    slv_t          s_d;
    logic [1:0]    ds_n;
    logic          as_fall;
    logic          ds_fall;
    logic          ds_rise;
    logic          cancel;
    logic          addr_hit;
    logic          mem_wr;
    logic          mem_rd;
    logic [DW-1:0] mem_rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // Edges of the bus lines against last cycle's samples

    assign ds_n     = {i_ds1_n, i_ds0_n};
    assign as_fall  = s_q.as_n & ~i_as_n;
    assign ds_fall  = |(s_q.ds_n & ~ds_n);
    assign ds_rise  = |(~s_q.ds_n & ds_n);
    assign cancel   = (s_q.dtack_n & ~i_dtack_n) | (s_q.berr_n & ~i_berr_n) | ds_rise;
    assign addr_hit = i_iack_n && (i_am == AM_CODE)
                      && (i_addr[AW-1:MEM_AW] == BASE_ADDR[AW-1:MEM_AW]);
    // Store is touched only once the strobes have settled, one cycle after the first fall
    assign mem_wr   = (s_q.st == dtb_pkg::ST_STRB) && i_lword_n && !i_write_n;
    assign mem_rd   = (s_q.st == dtb_pkg::ST_STRB) && i_lword_n && i_write_n;

    dtb_word_mem #(
        .AW (MEM_AW),
        .DW (DW)
    ) u_mem (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_addr    (s_q.idx),
        .i_wr      (mem_wr),
        .i_be      (~ds_n),
        .i_wdata   (i_data),
        .i_rd      (mem_rd),
        .o_rdata   (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_d         = s_q;
        s_d.as_n    = i_as_n;
        s_d.ds_n    = ds_n;
        s_d.dtack_n = i_dtack_n;
        s_d.berr_n  = i_berr_n;

        case (s_q.st)
            dtb_pkg::ST_IDLE: begin
                if (as_fall && addr_hit) begin // R7
                    s_d.st  = dtb_pkg::ST_SEL;
                    s_d.idx = i_addr[MEM_AW-1:0];
                end
            end
            dtb_pkg::ST_SEL: begin
                if (i_as_n) begin
                    s_d.st = dtb_pkg::ST_IDLE;
                end else if (ds_fall) begin // R17
                    s_d.st = dtb_pkg::ST_STRB;
                end
            end
            dtb_pkg::ST_STRB: begin
                if (!i_lword_n || ds_n == 2'h3) begin // R18
                    s_d.st    = dtb_pkg::ST_ERR;
                    s_d.sberr = 1'b1;
                end else if (!i_write_n) begin // R15
                    s_d.st    = dtb_pkg::ST_ACK;
                    s_d.dtack = 1'b1;
                end else begin
                    s_d.st = dtb_pkg::ST_RDWAIT;
                end
            end
            dtb_pkg::ST_RDWAIT: begin
                s_d.st   = dtb_pkg::ST_DRIVE;
                s_d.data = mem_rdata;
                s_d.oe   = ~ds_n; // R18
            end
            dtb_pkg::ST_DRIVE: begin
                s_d.st    = dtb_pkg::ST_ACK;
                s_d.dtack = 1'b1; // R11
            end
            dtb_pkg::ST_ACK, dtb_pkg::ST_ERR: begin
                if (i_as_n && ds_n == 2'h3) begin // R14
                    s_d.st    = dtb_pkg::ST_IDLE;
                    s_d.dtack = 1'b0;
                    s_d.sberr = 1'b0;
                    s_d.oe    = dtb_pkg::LANES_OFF;
                end
            end
            default: begin
                s_d.st = dtb_pkg::ST_IDLE;
            end
        endcase

        // Time-out monitor: watches the wired bus lines, so it also guards other slaves
        if (s_q.tmo_berr) begin
            if (ds_rise) begin
                s_d.tmo_berr = 1'b0; // R4
            end
        end else if (s_q.tmo_run) begin
            if (cancel) begin
                s_d.tmo_run = 1'b0; // R3
            end else if (s_q.tmo_cnt == 32'(TIMEOUT_CYC - 1)) begin
                s_d.tmo_run  = 1'b0;
                s_d.tmo_berr = 1'b1; // R1
            end else begin
                s_d.tmo_cnt = s_q.tmo_cnt + 32'h00000001; // R20
            end
        end
        if (ds_fall && !s_q.tmo_berr) begin // R2
            s_d.tmo_run = 1'b1;
            s_d.tmo_cnt = 32'h00000000;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            s_q         <= '0;
            s_q.st      <= dtb_pkg::ST_IDLE;
            s_q.as_n    <= dtb_pkg::LINE_IDLE;
            s_q.ds_n    <= {2{dtb_pkg::LINE_IDLE}};
            s_q.dtack_n <= dtb_pkg::LINE_IDLE;
            s_q.berr_n  <= dtb_pkg::LINE_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_data     = s_q.data;
    assign o_data_oe  = s_q.oe;
    assign o_dtack_oe = s_q.dtack;
    assign o_berr_oe  = s_q.sberr | s_q.tmo_berr;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_tmo_expire;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (s_q.tmo_run && !s_q.tmo_berr && !cancel && !ds_fall
         && s_q.tmo_cnt == 32'(TIMEOUT_CYC - 1)) |=> o_berr_oe;
    endproperty
    a_tmo_expire: assert property (p_tmo_expire) else $error("time-out did not raise error"); // R1

    property p_tmo_after_fall;
        @(posedge i_mclk) disable iff (!i_reset_n)
        $rose(s_q.tmo_berr) |-> $past(s_q.tmo_run) && $past(s_q.ds_n) != 2'h3;
    endproperty
    a_tmo_after_fall: assert property (p_tmo_after_fall) else $error("error before strobe"); // R2

    property p_tmo_cancel;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (s_q.tmo_run && cancel && !ds_fall) |=> !s_q.tmo_run ##1 !$rose(s_q.tmo_berr);
    endproperty
    a_tmo_cancel: assert property (p_tmo_cancel) else $error("time-out not cancelled"); // R3

    property p_tmo_release;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (s_q.tmo_berr && ds_rise) |=> !s_q.tmo_berr;
    endproperty
    a_tmo_release: assert property (p_tmo_release) else $error("time-out error held"); // R4

    property p_no_select;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (s_q.st == dtb_pkg::ST_IDLE && as_fall && !addr_hit) |=> s_q.st == dtb_pkg::ST_IDLE;
    endproperty
    a_no_select: assert property (p_no_select) else $error("selected without match"); // R7

    property p_read_hold;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (s_q.dtack && s_q.oe != 2'h0 && ds_n != 2'h3)
        |=> $stable(o_data) && $stable(o_data_oe) && o_dtack_oe;
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read data not held"); // R11

    property p_data_first;
        @(posedge i_mclk) disable iff (!i_reset_n)
        // Direction as taken with the strobes; the master may change it once answered
        ($rose(o_dtack_oe) && $past(i_write_n, 3)) |-> $past(o_data_oe) != 2'h0;
    endproperty
    a_data_first: assert property (p_data_first) else $error("ack before read data"); // R11

    property p_release;
        @(posedge i_mclk) disable iff (!i_reset_n)
        ((s_q.dtack || s_q.sberr) && i_as_n && ds_n == 2'h3)
        |=> !o_dtack_oe && o_data_oe == 2'h0 && !s_q.sberr;
    endproperty
    a_release: assert property (p_release) else $error("lines not released"); // R14

    property p_write_ack;
        @(posedge i_mclk) disable iff (!i_reset_n)
        mem_wr |-> !o_dtack_oe ##1 o_dtack_oe;
    endproperty
    a_write_ack: assert property (p_write_ack) else $error("write not acknowledged"); // R15

    property p_wait_strobe;
        @(posedge i_mclk) disable iff (!i_reset_n)
        ($rose(o_dtack_oe) || $rose(s_q.sberr)) |-> $past(s_q.ds_n) != 2'h3;
    endproperty
    a_wait_strobe: assert property (p_wait_strobe) else $error("answer before strobe"); // R17

    property p_long_err;
        @(posedge i_mclk) disable iff (!i_reset_n)
        (s_q.st == dtb_pkg::ST_STRB && !i_lword_n) |=> s_q.sberr && !o_dtack_oe;
    endproperty
    a_long_err: assert property (p_long_err) else $error("long word not refused"); // R18

endmodule

// [tb/dtb_master_model.sv]
// Bus master model driving address, modifier, strobes, direction and write data
`timescale 1ns/1ns
module dtb_master_model (
    input  wire logic        i_mclk,
    input  wire logic        i_grant,
    input  wire logic        i_dtack_n,
    input  wire logic        i_berr_n,
    input  wire logic [15:0] i_data,
    output logic      [22:0] o_addr,
    output logic      [5:0]  o_am,
    output logic             o_iack_n,
    output logic             o_lword_n,
    output logic             o_write_n,
    output logic             o_as_n,
    output logic             o_ds0_n,
    output logic             o_ds1_n,
    output logic      [15:0] o_data
);
    initial begin
        {o_addr, o_am, o_iack_n, o_lword_n, o_write_n} = '1;
        {o_as_n, o_ds0_n, o_ds1_n, o_data} = '1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Resp 0 none, 1 acknowledge, 2 bus error; lat and rel count falling edges
    task automatic cycle(input logic [22:0] a, input logic [5:0] am, input logic iack_n,
                         input logic lw_n, wr_n, d0_n, d1_n, input logic [15:0] wd,
                         input int hold, wmax, output logic [15:0] rd,
                         output int resp, lat, rel, output logic bad);
        int i;
        bad = 1'b0;
        resp = 0;
        rel = 0;
        for (i = 0; i < 50 && i_grant !== 1'b1; i++) @(negedge i_mclk);
        if (i_grant !== 1'b1) bad = 1'b1;
        o_addr = a;
        o_am = am;
        o_iack_n = iack_n;
        o_lword_n = lw_n;
        o_write_n = wr_n;
        if (!wr_n) o_data = wd;
        @(negedge i_mclk);
        o_as_n = 1'b0;
        // Slave must stay silent here, and the lines must be free before a strobe
        for (i = 0; i < 2; i++) begin
            @(negedge i_mclk);
            if (i_dtack_n !== 1'b1 || i_berr_n !== 1'b1) bad = 1'b1;
        end
        o_ds0_n = d0_n;
        o_ds1_n = d1_n;
        for (lat = 0; lat < wmax && resp == 0; ) begin
            @(negedge i_mclk);
            lat++;
            if (i_dtack_n === 1'b0) resp = 1;
            else if (i_berr_n === 1'b0) resp = 2;
        end
        rd = i_data;
        for (i = 0; i < hold; i++) begin
            @(negedge i_mclk);
            if (resp == 1 && (i_data !== rd || i_dtack_n !== 1'b0 || i_berr_n !== 1'b1))
                bad = 1'b1;
        end
        // Released lines show the inverse of their last level, pulled-up ones go high
        o_addr = ~a;
        o_am = ~am;
        o_data = ~o_data;
        {o_iack_n, o_lword_n, o_write_n} = 3'h7;
        @(negedge i_mclk);
        {o_ds0_n, o_ds1_n, o_as_n} = 3'h7;
        for (i = 1; i <= 8 && rel == 0; i++) begin
            @(negedge i_mclk);
            if (i_dtack_n === 1'b1 && i_berr_n === 1'b1) rel = i;
        end
    endtask
endmodule

// [tb/async_bus_transfer_handshake_bench.sv]
// Self-checking bench of the bus slave and its time-out monitor
`timescale 1ns/1ns
module async_bus_transfer_handshake_bench;
    localparam int TO = 8;
    localparam int RC = dtb_pkg::RELEASE_CYC;
    logic        i_mclk, i_reset_n, grant;
    logic [22:0] addr;
    logic [5:0]  am;
    logic        iack_n, lword_n, write_n, as_n, ds0_n, ds1_n, dtack_oe, berr_oe;
    logic [15:0] m_data, s_data, bus_data;
    logic [1:0]  data_oe;
    logic [15:0] mirror [0:15];
    int          error_cnt = 0;
    int          n_tests = 0;
    // Wired lines: only this slave pulls acknowledge and error low
    wire dtack_n = ~dtack_oe;
    wire berr_n = ~berr_oe;
    assign bus_data = {data_oe[1] ? s_data[15:8] : m_data[15:8],
                       data_oe[0] ? s_data[7:0] : m_data[7:0]};

    dtb_slave #(.TIMEOUT_CYC(TO)) u_dut (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(addr), .i_am(am),
        .i_iack_n(iack_n), .i_lword_n(lword_n), .i_write_n(write_n), .i_as_n(as_n),
        .i_ds0_n(ds0_n), .i_ds1_n(ds1_n), .i_data(bus_data), .o_data(s_data),
        .o_data_oe(data_oe), .i_dtack_n(dtack_n), .o_dtack_oe(dtack_oe),
        .i_berr_n(berr_n), .o_berr_oe(berr_oe));

    dtb_master_model u_mst (
        .i_mclk(i_mclk), .i_grant(grant), .i_dtack_n(dtack_n), .i_berr_n(berr_n),
        .i_data(bus_data), .o_addr(addr), .o_am(am), .o_iack_n(iack_n),
        .o_lword_n(lword_n), .o_write_n(write_n), .o_as_n(as_n), .o_ds0_n(ds0_n),
        .o_ds1_n(ds1_n), .o_data(m_data));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] merge(logic [15:0] old, nw, logic d0_n, d1_n);
        return {d1_n ? old[15:8] : nw[15:8], d0_n ? old[7:0] : nw[7:0]};
    endfunction

    task automatic check(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Matched 16-bit cycle, checked against the mirror of the store
    task automatic op(input logic [3:0] idx, input logic wr_n, d0_n, d1_n,
                      input logic [15:0] wd, input int hold);
        logic [15:0] rd;
        int          resp, lat, rel;
        logic        bad;
        u_mst.cycle(23'(idx), dtb_pkg::DEF_AM_CODE, 1'b1, 1'b1, wr_n, d0_n, d1_n, wd, hold,
                    20, rd, resp, lat, rel, bad);
        check(32'(resp), 1);
        check(32'(lat), wr_n ? 4 : 2);
        check(bad, 0);
        check(rel >= 1 && rel <= RC, 1);
        if (!wr_n) mirror[idx] = merge(mirror[idx], wd, d0_n, d1_n);
        else check(merge(16'h0000, rd, d0_n, d1_n), merge(16'h0000, mirror[idx], d0_n, d1_n));
    endtask

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    initial begin
        logic [15:0] rd;
        logic [1:0]  ds;
        int          resp, lat, rel, i, j;
        logic        bad;
        logic [22:0] ba [0:2];
        logic [5:0]  bm [0:2];
        logic        bi [0:2];
        ba = '{23'h000400, 23'h000001, 23'h000002};
        bm = '{dtb_pkg::DEF_AM_CODE, ~dtb_pkg::DEF_AM_CODE, dtb_pkg::DEF_AM_CODE};
        bi = '{1'b1, 1'b1, 1'b0};
        i_reset_n = 1'b0;
        grant = 1'b0;
        for (i = 0; i < 16; i++) mirror[i] = 16'h0000;
        void'($urandom(32'h6DF2));
        repeat (6) @(negedge i_mclk);
        check({dtack_oe, berr_oe, data_oe, s_data}, 0);
        i_reset_n = 1'b1;
        grant = 1'b1;
        @(negedge i_mclk);
        $display("Test reset done");
        op(4'h1, 1'b0, 1'b0, 1'b0, 16'hA55A, 0);
        op(4'h1, 1'b0, 1'b0, 1'b1, 16'h12C3, 0);
        op(4'h1, 1'b1, 1'b0, 1'b0, 16'h0000, TO + 4);
        $display("Test lanes done");
        for (i = 0; i < 40; i++) begin
            ds = 2'($urandom_range(0, 2));
            op(4'($urandom), 1'($urandom), ds[0], ds[1], 16'($urandom), $urandom_range(0, 2));
        end
        $display("Test random done");
        // Foreign address, foreign modifier, interrupt acknowledge: only the monitor answers
        for (j = 0; j < 3; j++) begin
            u_mst.cycle(ba[j], bm[j], bi[j], 1'b1, 1'b1, 1'b0, 1'b1, 16'h0000, 0, 20, rd,
                        resp, lat, rel, bad);
            check(32'(resp), 2);
            check(32'(lat), TO + 1);
            check(bad, 0);
            check(rel >= 1 && rel <= RC, 1);
        end
        u_mst.cycle(23'h000003, dtb_pkg::DEF_AM_CODE, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0,
                    16'h0000, 0, 20, rd, resp, lat, rel, bad);
        check(32'(resp), 2);
        check(32'(lat), 2);
        $display("Test errors done");
        // Strobe rise before expiry must cancel the pending error
        u_mst.cycle(23'h000400, dtb_pkg::DEF_AM_CODE, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0,
                    16'h0000, 0, TO - 3, rd, resp, lat, rel, bad);
        check(32'(resp), 0);
        bad = 1'b0;
        for (i = 0; i < TO + 4; i++) begin
            @(negedge i_mclk);
            if (berr_n !== 1'b1) bad = 1'b1;
        end
        check(bad, 0);
        $display("Test cancel done");
        summarize();
    end
endmodule
